// File: rtl/mcuirq_ctrl.sv
// Interrupt control logic of an 8-bit microcontroller core.
// Assumes the core and all sources share ref_clk_i; one instruction
// cycle is four clocks (Q1..Q4), counted here and exported to the core.
`include "mcuirq_map.svh"
`timescale 1ns/1ns
`default_nettype none

module mcuirq_ctrl #(
  parameter int PORT_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire mcuirq_pkg::mcuirq_core_in_type core_i,
  output mcuirq_pkg::mcuirq_core_out_type core_o,
  input wire logic external_irq_pin_i,
  input wire logic pin_lcd_active_i,
  input wire logic [7:0] timer_zero_count_i,
  input wire logic [PORT_W-1:0] port_b_i,
  input wire logic [7:0] pflag_one_set_i,
  input wire logic [7:0] pflag_two_set_i
);

  // Reset image of the whole state record
  // Port reference starts at zero: a pin already high after reset
  // counts as a change once its mask bit is set, until a port read
  // re-arms the reference. Software reads the port before enabling.
  localparam mcuirq_pkg::mcuirq_state_type RESET_STATE = '{
    phase: `MCUIRQ_PHASE_Q1,
    ctrl: `MCUIRQ_CORE_CTRL_RESET,
    pflag_one: `MCUIRQ_PFLAG_RESET,
    pflag_two: `MCUIRQ_PFLAG_RESET,
    pen_one: `MCUIRQ_PEN_RESET,
    pen_two: `MCUIRQ_PEN_RESET,
    option: `MCUIRQ_OPTION_RESET,
    pin_chg_en: `MCUIRQ_PIN_CHG_EN_RESET,
    port_ref: 8'h00,
    timer_prev: 8'h00,
    pin_prev: 1'b0,
    edge_held: 1'b0,
    seq: mcuirq_pkg::MCUIRQ_IDLE,
    rdata: 8'h00,
    take: 1'b0,
    wake: 1'b0,
    push_addr: 13'h0000
  };

  mcuirq_pkg::mcuirq_state_type st_reg;
  mcuirq_pkg::mcuirq_state_type st_next;

  // Address match, shared by write decode and read mux
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  function automatic logic is_core_ctrl(input logic [7:0] a);
    is_core_ctrl = addr_is(a, `MCUIRQ_OFF_CORE_CTRL) |
                   addr_is(a, `MCUIRQ_OFF_CORE_CTRL_ALT);
  endfunction : is_core_ctrl

  // Edge qualifier, shared by both polarities of the pin
  function automatic logic edge_seen(input logic prev, input logic now, input logic rising);
    if (rising) begin
      edge_seen = now & ~prev;
    end else begin
      edge_seen = ~now & prev;
    end
  endfunction : edge_seen

  // Flag bank against its enables; same term for both banks
  function automatic logic any_enabled(input logic [7:0] flags, input logic [7:0] enables);
    any_enabled = |(flags & enables);
  endfunction : any_enabled

  // Bank two has holes; writes and sets never reach them
  function automatic logic [7:0] impl_two(input logic [7:0] d);
    impl_two = d & `MCUIRQ_TWO_IMPL_MASK;
  endfunction : impl_two

  // Overflow only; a software load of zero is not a wrap
  function automatic logic wrapped(input logic [7:0] prev, input logic [7:0] now);
    wrapped = (prev == `MCUIRQ_TIMER_TOP) && (now == `MCUIRQ_TIMER_WRAP);
  endfunction : wrapped

  // Per-pin change detect; the port is widened to a byte for storage
  // A pin left different keeps setting the flag until the reference
  // is re-armed, so a software clear alone does not stick
  logic [7:0] port_now;
  logic [7:0] pin_changed;
  assign port_now = 8'(port_b_i);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_chg
      assign pin_changed[gi] = (port_now[gi] ^ st_reg.port_ref[gi]) &
                               st_reg.pin_chg_en[gi];
    end
  endgenerate

  // Pending terms from the registered flags and enables
  logic core_hit;
  logic periph_hit;
  logic any_hit;
  logic service;
  logic pin_wake;
  logic timer_hit;
  logic pin_hit;
  logic change_hit;
  logic periph_one_hit;
  logic periph_two_hit;

  // each flag ANDed with its enable
  assign timer_hit = st_reg.ctrl[`MCUIRQ_TIMER_ZERO_ROLLOVER_FLAG] &
                     st_reg.ctrl[`MCUIRQ_TIMER_ZERO_IRQ_ENABLE];
  assign pin_hit = st_reg.ctrl[`MCUIRQ_PIN_IRQ_FLAG] &
                   st_reg.ctrl[`MCUIRQ_PIN_IRQ_ENABLE];
  assign change_hit = st_reg.ctrl[`MCUIRQ_PORT_CHANGE_FLAG] &
                      st_reg.ctrl[`MCUIRQ_PORT_CHANGE_ENABLE];
  assign core_hit = timer_hit | pin_hit | change_hit;

  // peripheral group under its own enable
  assign periph_one_hit = any_enabled(st_reg.pflag_one, st_reg.pen_one);
  assign periph_two_hit = any_enabled(st_reg.pflag_two, st_reg.pen_two);
  assign periph_hit = st_reg.ctrl[`MCUIRQ_PERIPHERAL_GROUP_ENABLE] &
                      (periph_one_hit | periph_two_hit);

  assign any_hit = core_hit | periph_hit;

  assign service = st_reg.ctrl[`MCUIRQ_GLOBAL_IRQ_ENABLE] & any_hit;

  // wake does not look at the global enable
  assign pin_wake = any_hit;

  // Next-state of the whole block
  always_comb begin
    logic cycle_end;
    logic pin_rise;
    logic pin_fall;
    logic pin_edge;
    logic edge_window;
    logic timer_wrap;
    logic gie_now;
    cycle_end = 1'b0;
    pin_rise = 1'b0;
    pin_fall = 1'b0;
    pin_edge = 1'b0;
    edge_window = 1'b0;
    timer_wrap = 1'b0;
    gie_now = 1'b0;
    st_next = st_reg;

    // Free-running Q phase; Q4 closes each instruction cycle
    st_next.phase = st_reg.phase + 2'h1;
    cycle_end = (st_reg.phase == `MCUIRQ_PHASE_Q4);
    edge_window = cycle_end | (st_reg.phase == `MCUIRQ_PHASE_Q1);

    // Pulses last one clock unless reissued
    st_next.take = 1'b0;
    st_next.wake = 1'b0;
    st_next.pin_prev = external_irq_pin_i;
    st_next.timer_prev = timer_zero_count_i;

    // Register writes; unmapped offsets are ignored
    // Writes land first; the event sets further down win over a
    // software clear in the same clock
    if (reg_wr_i) begin
      if (is_core_ctrl(reg_addr_i)) begin
        st_next.ctrl = reg_wdata_i;
      end
      if (addr_is(reg_addr_i, `MCUIRQ_OFF_PFLAG_ONE)) begin
        st_next.pflag_one = reg_wdata_i;
      end
      if (addr_is(reg_addr_i, `MCUIRQ_OFF_PFLAG_TWO)) begin
        st_next.pflag_two = impl_two(reg_wdata_i);
      end
      if (addr_is(reg_addr_i, `MCUIRQ_OFF_PEN_ONE)) begin
        st_next.pen_one = reg_wdata_i;
      end
      if (addr_is(reg_addr_i, `MCUIRQ_OFF_PEN_TWO)) begin
        st_next.pen_two = impl_two(reg_wdata_i);
      end
      if (addr_is(reg_addr_i, `MCUIRQ_OFF_OPTION)) begin
        st_next.option = reg_wdata_i;
      end
      if (addr_is(reg_addr_i, `MCUIRQ_OFF_PIN_CHG_EN)) begin
        st_next.pin_chg_en = reg_wdata_i;
      end
    end

    // Read data stands only in the cycle after the strobe
    // Reads show the registered copy, so a flag set in the read clock
    // appears on the following read
    st_next.rdata = 8'h00;
    if (reg_rd_i) begin
      if (is_core_ctrl(reg_addr_i)) begin
        st_next.rdata = st_reg.ctrl;
      end else if (addr_is(reg_addr_i, `MCUIRQ_OFF_PFLAG_ONE)) begin
        st_next.rdata = st_reg.pflag_one;
      end else if (addr_is(reg_addr_i, `MCUIRQ_OFF_PFLAG_TWO)) begin
        st_next.rdata = st_reg.pflag_two;
      end else if (addr_is(reg_addr_i, `MCUIRQ_OFF_PEN_ONE)) begin
        st_next.rdata = st_reg.pen_one;
      end else if (addr_is(reg_addr_i, `MCUIRQ_OFF_PEN_TWO)) begin
        st_next.rdata = st_reg.pen_two;
      end else if (addr_is(reg_addr_i, `MCUIRQ_OFF_OPTION)) begin
        st_next.rdata = st_reg.option;
      end else if (addr_is(reg_addr_i, `MCUIRQ_OFF_PIN_CHG_EN)) begin
        st_next.rdata = st_reg.pin_chg_en;
      end
    end

    pin_rise = edge_seen(st_reg.pin_prev, external_irq_pin_i, 1'b1);
    pin_fall = edge_seen(st_reg.pin_prev, external_irq_pin_i, 1'b0);
    pin_edge = st_reg.option[`MCUIRQ_PIN_EDGE_SELECT] ? pin_rise : pin_fall;
    // LCD drive masks the pin interrupt
    pin_edge = pin_edge & ~pin_lcd_active_i;

    // An edge in Q2 or Q3 is parked in edge_held and committed at the
    // next Q4, so an edge only ever sets the flag in the Q4 and Q1 window
    // edges outside Q4/Q1 wait for the window
    if (edge_window) begin
      st_next.edge_held = 1'b0;
      // valid edge sets pin flag; set beats a clear
      if (pin_edge | st_reg.edge_held) begin
        st_next.ctrl[`MCUIRQ_PIN_IRQ_FLAG] = 1'b1;
      end
    end else if (pin_edge) begin
      st_next.edge_held = 1'b1;
    end

    // wrap from top to zero sets the timer flag
    timer_wrap = wrapped(st_reg.timer_prev, timer_zero_count_i);
    if (timer_wrap) begin
      st_next.ctrl[`MCUIRQ_TIMER_ZERO_ROLLOVER_FLAG] = 1'b1;
    end

    // any enabled pin mismatch sets the change flag
    if (|pin_changed) begin
      st_next.ctrl[`MCUIRQ_PORT_CHANGE_FLAG] = 1'b1;
    end
    // a port read re-arms the reference; a change in the
    // same clock still sets the flag against the old reference
    if (core_i.port_read) begin
      st_next.port_ref = port_now;
    end

    // peripheral flags set regardless of enables, set wins
    st_next.pflag_one = st_next.pflag_one | pflag_one_set_i;
    st_next.pflag_two = st_next.pflag_two |
                        impl_two(pflag_two_set_i);

    // handler return re-arms the global enable
    if (core_i.return_from_handler_instr) begin
      st_next.ctrl[`MCUIRQ_GLOBAL_IRQ_ENABLE] = 1'b1;
    end
    // Decisions use the enable as it stands after this clock's write
    // and return, so a clear at the boundary already blocks entry
    gie_now = st_next.ctrl[`MCUIRQ_GLOBAL_IRQ_ENABLE];

    // Entry walk: a boundary that sees an enabled request moves to
    // recognition, the next boundary to the flush cycle, and the third
    // raises take with the enable cleared. The fixed two-cycle tail keeps
    // latency the same whatever the core executes; the cost is that a
    // request set just after a boundary waits almost a cycle.
    // Entry sequencer, advancing only at instruction-cycle boundaries
    case (st_reg.seq)
      mcuirq_pkg::MCUIRQ_IDLE: begin
        if (cycle_end) begin
          // Asleep: any enabled source wakes, the global enable only
          // picks between vectoring and running on in sequence
          if (core_i.asleep) begin
            if (pin_wake) begin
              st_next.wake = 1'b1;
              // branch only with global enable set
              if (gie_now) begin
                st_next.seq = mcuirq_pkg::MCUIRQ_WAKE_EXEC;
              end
            end
          end else if (service & gie_now) begin
            st_next.seq = mcuirq_pkg::MCUIRQ_RECOG;
          end
        end
      end
      mcuirq_pkg::MCUIRQ_WAKE_EXEC: begin
        // one instruction after wake before vectoring
        // The core runs the instruction after the sleep first
        if (cycle_end) begin
          st_next.seq = mcuirq_pkg::MCUIRQ_RECOG;
        end
      end
      mcuirq_pkg::MCUIRQ_RECOG: begin
        if (cycle_end) begin
          // cleared enable drops entry, flags stay pending
          // The flags are untouched, so entry resumes once re-enabled
          if (!gie_now) begin
            st_next.seq = mcuirq_pkg::MCUIRQ_IDLE;
          end else begin
            st_next.seq = mcuirq_pkg::MCUIRQ_FLUSH;
          end
        end
      end
      mcuirq_pkg::MCUIRQ_FLUSH: begin
        // dummy cycle evens out one- and two-cycle opcodes
        // A flag cleared by software here still lets entry go ahead;
        // the handler then polls and finds nothing, which is harmless
        if (cycle_end) begin
          st_next.seq = mcuirq_pkg::MCUIRQ_IDLE;
          if (gie_now) begin
            // clear enable, push return PC, vector
            st_next.ctrl[`MCUIRQ_GLOBAL_IRQ_ENABLE] = 1'b0;
            st_next.take = 1'b1;
            // only the return PC is handed to the stack
            st_next.push_addr = core_i.return_pc;
          end
        end
      end
      default: begin
        st_next.seq = mcuirq_pkg::MCUIRQ_IDLE;
      end
    endcase
  end

  // State register
  // Synchronous reset only; the reset image is all constants
  always_ff @(posedge ref_clk_i) begin
    // reset clears the global enable with all else
    if (!resetn_i) begin
      st_reg <= RESET_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state record, bar the fixed vector
  // take and push_addr come from one edge, so the core may push and
  // load the vector in the same clock; push_addr then holds
  assign reg_rdata_o = st_reg.rdata;
  assign core_o.take = st_reg.take;
  assign core_o.wake = st_reg.wake;
  assign core_o.push_addr = st_reg.push_addr;
  assign core_o.vector_pc = `MCUIRQ_VECTOR_PC; // Fixed handler address
  assign core_o.phase = st_reg.phase;

endmodule : mcuirq_ctrl

`default_nettype wire

// File: rtl/mcuirq_map.svh
// Register offsets, bit positions, reset values and timing for the
// interrupt controller. Assumes an 8-bit register port with byte offsets.
`ifndef MCUIRQ_MAP_SVH
`define MCUIRQ_MAP_SVH

// Register offsets
`define MCUIRQ_OFF_CORE_CTRL 8'h0b
`define MCUIRQ_OFF_CORE_CTRL_ALT 8'h8b
`define MCUIRQ_OFF_PFLAG_ONE 8'h0c
`define MCUIRQ_OFF_PFLAG_TWO 8'h0d
`define MCUIRQ_OFF_PEN_ONE 8'h8c
`define MCUIRQ_OFF_PEN_TWO 8'h8d
`define MCUIRQ_OFF_OPTION 8'h81
`define MCUIRQ_OFF_PIN_CHG_EN 8'h95

// Core control register fields, then the option register edge select bit
`define MCUIRQ_GLOBAL_IRQ_ENABLE 7
`define MCUIRQ_PERIPHERAL_GROUP_ENABLE 6
`define MCUIRQ_TIMER_ZERO_IRQ_ENABLE 5
`define MCUIRQ_PIN_IRQ_ENABLE 4
`define MCUIRQ_PORT_CHANGE_ENABLE 3
`define MCUIRQ_TIMER_ZERO_ROLLOVER_FLAG 2
`define MCUIRQ_PIN_IRQ_FLAG 1
`define MCUIRQ_PORT_CHANGE_FLAG 0
`define MCUIRQ_PIN_EDGE_SELECT 6

// Reset values and implemented-bit masks
`define MCUIRQ_CORE_CTRL_RESET 8'h00
`define MCUIRQ_PFLAG_RESET 8'h00
`define MCUIRQ_PEN_RESET 8'h00
`define MCUIRQ_OPTION_RESET 8'h00
`define MCUIRQ_PIN_CHG_EN_RESET 8'h00
`define MCUIRQ_TWO_IMPL_MASK 8'hf5

// Timing and vector
`define MCUIRQ_PHASE_Q1 2'h0
`define MCUIRQ_PHASE_Q2 2'h1
`define MCUIRQ_PHASE_Q4 2'h3
`define MCUIRQ_TIMER_TOP 8'hff
`define MCUIRQ_TIMER_WRAP 8'h00
`define MCUIRQ_VECTOR_PC 13'h0004

`endif

// File: rtl/mcuirq_pkg.sv
// Types for the interrupt controller: sequencer states, core port
// carriers and the single state record of the controller.
package mcuirq_pkg;

  typedef enum logic [1:0] {
    MCUIRQ_IDLE = 2'b00,
    MCUIRQ_RECOG = 2'b01,
    MCUIRQ_FLUSH = 2'b10,
    MCUIRQ_WAKE_EXEC = 2'b11
  } mcuirq_seq_type;

  typedef struct packed {
    logic asleep;
    logic return_from_handler_instr;
    logic port_read;
    logic [12:0] return_pc;
  } mcuirq_core_in_type;

  typedef struct packed {
    logic take;
    logic wake;
    logic [12:0] push_addr;
    logic [12:0] vector_pc;
    logic [1:0] phase;
  } mcuirq_core_out_type;

  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] ctrl;
    logic [7:0] pflag_one;
    logic [7:0] pflag_two;
    logic [7:0] pen_one;
    logic [7:0] pen_two;
    logic [7:0] option;
    logic [7:0] pin_chg_en;
    logic [7:0] port_ref;
    logic [7:0] timer_prev;
    logic pin_prev;
    logic edge_held;
    mcuirq_seq_type seq;
    logic [7:0] rdata;
    logic take;
    logic wake;
    logic [12:0] push_addr;
  } mcuirq_state_type;

endpackage : mcuirq_pkg

// File: tb/mcuirq_checker.sv
// Port checker for the interrupt controller.
// Sees only the controller's ports; bound in from the bench top file.
`timescale 1ns/1ns
`default_nettype none
module mcuirq_checker #(
  parameter int PORT_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire mcuirq_pkg::mcuirq_core_in_type core_i,
  input wire mcuirq_pkg::mcuirq_core_out_type core_o,
  input wire logic external_irq_pin_i,
  input wire logic pin_lcd_active_i,
  input wire logic [7:0] timer_zero_count_i,
  input wire logic [PORT_W-1:0] port_b_i,
  input wire logic [7:0] pflag_one_set_i,
  input wire logic [7:0] pflag_two_set_i
);
  logic gie_reg;
  logic gie_next;
  // Global enable shadow; entry beats return beats write
  always_comb begin
    gie_next = gie_reg;
    if (reg_wr_i && (reg_addr_i == 8'h0b || reg_addr_i == 8'h8b)) gie_next = reg_wdata_i[7];
    if (core_i.return_from_handler_instr) gie_next = 1'b1;
    if (core_o.take || !resetn_i) gie_next = 1'b0;
  end
  always_ff @(posedge ref_clk_i) begin
    gie_reg <= gie_next;
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // Entry pulse and the quiet span a fresh entry needs
  sequence s_take;
    core_o.take;
  endsequence
  sequence s_quiet;
    !core_o.take [*8];
  endsequence
  AST_TAKE_SPACED: assert property (s_take |=> s_quiet)
    else $error("entry pulses too close");
  AST_TAKE_GIE: assert property (s_take |-> gie_reg)
    else $error("entry with global enable off");
  AST_TAKE_Q1: assert property (s_take |-> core_o.phase == 2'h0)
    else $error("entry off the cycle boundary");
  AST_PUSH_PC: assert property (s_take |-> core_o.push_addr == $past(core_i.return_pc))
    else $error("pushed address wrong");
  AST_PUSH_HOLD: assert property (!core_o.take |-> $stable(core_o.push_addr))
    else $error("pushed address moved");
  AST_VECTOR: assert property (core_o.vector_pc == 13'h0004)
    else $error("vector address wrong");
  AST_WAKE: assert property (core_o.wake |-> $past(core_i.asleep) && core_o.phase == 2'h0)
    else $error("wake while awake or off boundary");
  AST_PHASE: assert property (resetn_i |=> core_o.phase == $past(core_o.phase) + 2'h1)
    else $error("phase counter skipped");
endmodule : mcuirq_checker
`default_nettype wire

// File: tb/mcuirq_core_model.sv
// Core-side model: program counter, sleep state and strobes.
// Assumes the controller's phase, entry and wake outputs.
`timescale 1ns/1ns
`default_nettype none
module mcuirq_core_model (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire mcuirq_pkg::mcuirq_core_out_type core_o,
  input wire logic sleep_i,
  input wire logic ret_i,
  input wire logic prd_i,
  output mcuirq_pkg::mcuirq_core_in_type core_i,
  output logic [7:0] takes_o
);
  logic [12:0] pc_reg;
  logic sleep_reg;
  // PC stalls in sleep, jumps on entry; entries counted
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pc_reg <= 13'h0000;
      sleep_reg <= 1'b0;
      takes_o <= 8'h00;
    end else begin
      if (core_o.take) pc_reg <= core_o.vector_pc;
      else if (core_o.phase == 2'h3 && !sleep_reg) pc_reg <= pc_reg + 13'h0001;
      if (core_o.take) takes_o <= takes_o + 8'h01;
      if (sleep_i) sleep_reg <= 1'b1;
      else if (core_o.wake) sleep_reg <= 1'b0;
    end
  end
  // Port reads only in Q2, as a real core would
  assign core_i = {sleep_reg, ret_i, prd_i && core_o.phase == 2'h1, pc_reg};
endmodule : mcuirq_core_model
`default_nettype wire

// File: tb/mcuirq_ctrl_tb.sv
// Self-checking bench for the interrupt controller and a core model.
// Assumes design files, checker and core model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module mcuirq_ctrl_tb;
  logic clk = 1'b0, rstn = 1'b0, wrs = 1'b0, rds = 1'b0, pin = 1'b0, lcd = 1'b0;
  logic slp = 1'b0, ret = 1'b0, prd = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, tmr = 8'h00, pb = 8'h00, pf1 = 8'h00, pf2 = 8'h00;
  logic [7:0] rdat, tk, t0, v;
  int fails = 0, n_tests = 0, n, i;
  mcuirq_pkg::mcuirq_core_in_type ci;
  mcuirq_pkg::mcuirq_core_out_type co;
  logic [7:0] offs [8] = '{8'h0b, 8'h0c, 8'h0d, 8'h8c, 8'h8d, 8'h81, 8'h95, 8'h8b};
  mcuirq_ctrl #(.PORT_W(8)) dut (.ref_clk_i(clk), .resetn_i(rstn), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wrs), .reg_rd_i(rds), .reg_rdata_o(rdat), .core_i(ci),
    .core_o(co), .external_irq_pin_i(pin), .pin_lcd_active_i(lcd), .timer_zero_count_i(tmr),
    .port_b_i(pb), .pflag_one_set_i(pf1), .pflag_two_set_i(pf2));
  mcuirq_core_model u_core (.ref_clk_i(clk), .resetn_i(rstn), .core_o(co), .sleep_i(slp),
    .ret_i(ret), .prd_i(prd), .core_i(ci), .takes_o(tk));
  // Free-running clock
  initial begin
    forever #5 clk = ~clk;
  end
  // Implemented bits of a flag or enable register
  function automatic logic [7:0] impl_mask(input logic [7:0] a);
    impl_mask = (a == 8'h0d || a == 8'h8d) ? 8'hf5 : 8'hff;
  endfunction : impl_mask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wrs <= 1'b1;
    @(posedge clk);
    wrs <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rds <= 1'b1;
    @(posedge clk);
    rds <= 1'b0;
    #1;
    chk(rdat & m, e);
  endtask : rc
  task automatic rst;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
  endtask : rst
  task automatic wrap;
    tmr <= 8'hff;
    @(posedge clk);
    tmr <= 8'h00;
  endtask : wrap
  task automatic give_verdict;
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Hang guard, far beyond the five hundred or so cycles needed
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    v = 8'($urandom(32'hc3c3));
    rst();
    foreach (offs[k]) rc(offs[k], 8'hff, 8'h00);
    wr(8'h10, v);
    rc(8'h10, 8'hff, 8'h00);
    // Flag and enable registers, unimplemented bits read 0
    for (i = 1; i < 5; i++) begin
      v = 8'($urandom);
      wr(offs[i], v);
      rc(offs[i], 8'hff, v & impl_mask(offs[i]));
      wr(offs[i], 8'h00);
    end
    // Timer: fe to ff is no wrap; ff to 00 flags with enables off
    t0 = tk;
    tmr <= 8'hfe;
    @(posedge clk);
    tmr <= 8'hff;
    repeat (3) @(posedge clk);
    rc(8'h0b, 8'hff, 8'h00);
    tmr <= 8'h00;
    repeat (3) @(posedge clk);
    rc(8'h0b, 8'hff, 8'h04);
    chk(tk - t0, 8'h00);
    // Both pin polarities, with and without the LCD function
    for (i = 0; i < 4; i++) begin
      wr(8'h81, {1'b0, i[0], 6'h00});
      lcd <= i[1];
      pin <= ~i[0];
      repeat (8) @(posedge clk);
      wr(8'h0b, 8'h00);
      pin <= i[0];
      repeat (8) @(posedge clk);
      rc(8'h0b, 8'h02, i[1] ? 8'h00 : 8'h02);
    end
    // Port change outside, then inside the per-pin mask
    i = $urandom % 8;
    wr(8'h95, 8'h01 << i);
    pb <= 8'($urandom);
    prd <= 1'b1;
    repeat (4) @(posedge clk);
    prd <= 1'b0;
    wr(8'h0b, 8'h00);
    pb <= pb ^ ~(8'h01 << i);
    repeat (4) @(posedge clk);
    rc(8'h0b, 8'hff, 8'h00);
    pb <= pb ^ (8'h01 << i);
    repeat (4) @(posedge clk);
    rc(8'h0b, 8'h01, 8'h01);
    wr(8'h95, 8'h00);
    // Pin entry latency, handler clears flag and returns
    lcd <= 1'b0;
    wr(8'h81, 8'h40);
    pin <= 1'b0;
    wr(8'h0b, 8'h90);
    pin <= 1'b1;
    n = 0;
    while (co.take !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n >= 12 && n <= 16), 8'h01);
    rc(8'h0b, 8'hff, 8'h12);
    wr(8'h0b, 8'h10);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    rc(8'h0b, 8'h80, 8'h80);
    // Global enable dropped under a due request: kept pending
    wr(8'h0b, 8'ha0);
    t0 = tk;
    wrap();
    wr(8'h0b, 8'h24);
    repeat (30) @(posedge clk);
    chk(tk - t0, 8'h00);
    rc(8'h0b, 8'h04, 8'h04);
    wr(8'h0b, 8'ha4);
    repeat (20) @(posedge clk);
    chk(tk - t0, 8'h01);
    wr(8'h0b, 8'h00);
    // Peripheral sources behind the group enable
    for (i = 0; i < 2; i++) begin
      n = $urandom % 8;
      n = (i == 1 && n inside {1, 3}) ? 0 : n;
      wr(offs[3 + i], 8'h01 << n);
      wr(8'h0b, 8'h80);
      t0 = tk;
      {pf2, pf1} <= 16'h0001 << (n + 8 * i);
      @(posedge clk);
      {pf2, pf1} <= 16'h0000;
      repeat (30) @(posedge clk);
      chk(tk - t0, 8'h00);
      rc(offs[1 + i], 8'hff, 8'h01 << n);
      wr(8'h0b, 8'hc0);
      repeat (20) @(posedge clk);
      chk(tk - t0, 8'h01);
      wr(offs[1 + i], 8'h00);
      wr(8'h0b, 8'h00);
    end
    // Wake by pin edge, vectoring only with global enable
    for (i = 0; i < 2; i++) begin
      pin <= 1'b0;
      wr(8'h0b, i ? 8'h90 : 8'h10);
      t0 = tk;
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      repeat (4) @(posedge clk);
      pin <= 1'b1;
      repeat (30) @(posedge clk);
      chk({7'h00, ci.asleep}, 8'h00);
      chk(tk - t0, i[7:0]);
    end
    wr(8'h0b, 8'hb8);
    rst();
    rc(8'h0b, 8'hff, 8'h00);
    give_verdict();
  end
endmodule : mcuirq_ctrl_tb
bind mcuirq_ctrl mcuirq_checker #(.PORT_W(PORT_W)) u_chk (.ref_clk_i, .resetn_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .core_i, .core_o, .external_irq_pin_i,
  .pin_lcd_active_i, .timer_zero_count_i, .port_b_i, .pflag_one_set_i, .pflag_two_set_i);
`default_nettype wire
